// >>> hdl/tsk_pkg.sv
// constants and types for the timer 3 skip and miscellaneous op decoder
package tsk_pkg;
   // instruction word
   localparam int OPC_W = 10;
   localparam logic [9:0] OP_SKIP_T3 = 10'h282;  // skip on timer three request
   localparam logic [9:0] OP_SW_RESET = 10'h001; // software system reset
   localparam logic [9:0] OP_SET_REF = 10'h059;  // set high-order reference flag
   localparam logic [9:0] OP_VDET_EN = 10'h293;  // drop detector on in powerdown
   // second interrupt control register
   localparam int CTRL_W = 4;
   localparam logic [3:0] CTRL_RST = 4'h0;
   localparam int IRQ2_T3_EN_BIT = 0;            // timer three interrupt enable
   // register byte addresses
   localparam int ADDR_W = 8;
   localparam logic [7:0] ADDR_IRQ_CTRL2 = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   // status register bit positions
   localparam int STAT_T3_FLAG = 0;
   localparam int STAT_REF_FLAG = 1;
   localparam int STAT_VDET = 2;
   localparam int STAT_SKIP = 3;
   // bus constants
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   // instruction sequencing states
   typedef enum logic [1:0] {
      SEQ_EXEC = 2'b01, // next instruction executes
      SEQ_SKIP = 2'b10  // next instruction is suppressed
   } tsk_seq_t;

   // one instruction slot from the core fetch path
   typedef struct packed {
      logic valid;
      logic [9:0] code;
   } tsk_instr_t;

   // complete block state
   typedef struct packed {
      tsk_seq_t seq;
      logic skip_pending;
      logic suppressed;
      logic t3_flag;
      logic ref_flag;
      logic vdet_en;
      logic sreset;
      logic [3:0] ctrl2;
      logic dph_wr;
      logic [7:0] dph_addr;
      logic [31:0] hrdata;
      logic hreadyout;
   } tsk_state_t;
endpackage : tsk_pkg

// >>> hdl/tsk_decoder.sv
// decode and execute of timer 3 skip, reference flag, detector enable and reset ops
//
// Functional notes
// (RULE_01) enable clear: skip next when request flag set
// (RULE_02) enable clear: skip op clears request flag
// (RULE_03) enable set: skip op is a no-op
// (RULE_04) enable is bit 0 of interrupt control two
// (RULE_05) set op forces reference flag, no skip
// (RULE_06) detector op keeps detector active in powerdown
// (RULE_07) skip suppresses exactly next instruction, no effects
`timescale 1ns/10ps
module tsk_decoder (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_nrst,
   // instruction slot and timer event
   input wire tsk_pkg::tsk_instr_t i_instr,
   input wire logic i_t3_event,
   // ahb-lite slave
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   // block state
   output logic o_skip_pending,
   output logic o_suppressed,
   output logic o_t3_flag,
   output logic o_ref_flag,
   output logic o_vdet_powerdown_en,
   output logic o_sys_reset_req,
   output logic [3:0] o_irq_ctrl2
);

   ////////////////////////////////////////////////////////////////////////////
   // state
   tsk_pkg::tsk_state_t st_reg; // registered state
   tsk_pkg::tsk_state_t st_next; // next state
   logic exec; // instruction slot executes this cycle
   logic t3_en; // timer three interrupt enable
   logic ahb_take; // address phase accepted

   // true when the slot carries the given opcode
   function automatic logic is_op(input tsk_pkg::tsk_instr_t ins,
                                  input logic [9:0] op);
      is_op = ins.valid && (ins.code == op);
   endfunction : is_op

   // status word seen by software
   function automatic logic [31:0] status_word(input tsk_pkg::tsk_state_t s);
      logic [31:0] w;
      w = tsk_pkg::WORD_ZERO;
      w[tsk_pkg::STAT_T3_FLAG] = s.t3_flag;
      w[tsk_pkg::STAT_REF_FLAG] = s.ref_flag;
      w[tsk_pkg::STAT_VDET] = s.vdet_en;
      w[tsk_pkg::STAT_SKIP] = s.skip_pending;
      status_word = w;
   endfunction : status_word

   assign exec = i_instr.valid && (st_reg.seq == tsk_pkg::SEQ_EXEC);
   assign t3_en = st_reg.ctrl2[tsk_pkg::IRQ2_T3_EN_BIT]; // [RULE_04]
   assign ahb_take = i_hsel && i_hready && (i_htrans == tsk_pkg::HTRANS_NONSEQ);

   ////////////////////////////////////////////////////////////////////////////
   // next-state logic
   always_comb begin
      st_next = st_reg;
      st_next.suppressed = 1'b0;
      st_next.sreset = 1'b0;
      // sequencing
      unique case (st_reg.seq)
         tsk_pkg::SEQ_EXEC: begin
            if (is_op(i_instr, tsk_pkg::OP_SKIP_T3) && !t3_en) begin
               st_next.t3_flag = 1'b0; // [RULE_02]
               if (st_reg.t3_flag) begin
                  st_next.seq = tsk_pkg::SEQ_SKIP; // [RULE_01]
               end
            end
            // with the enable set the skip op falls through untouched [RULE_03]
            if (is_op(i_instr, tsk_pkg::OP_SET_REF)) begin
               st_next.ref_flag = 1'b1; // [RULE_05]
            end
            if (is_op(i_instr, tsk_pkg::OP_VDET_EN)) begin
               st_next.vdet_en = 1'b1; // [RULE_06]
            end
            if (is_op(i_instr, tsk_pkg::OP_SW_RESET)) begin
               st_next.sreset = 1'b1;
            end
         end
         tsk_pkg::SEQ_SKIP: begin
            // the next slot is dropped with no side effects
            if (i_instr.valid) begin
               st_next.seq = tsk_pkg::SEQ_EXEC; // [RULE_07]
               st_next.suppressed = 1'b1; // [RULE_07]
            end
         end
      endcase
      // timer event sets the request flag; set beats the skip-op clear above
      if (i_t3_event) begin
         st_next.t3_flag = 1'b1;
      end
      st_next.skip_pending = (st_next.seq == tsk_pkg::SEQ_SKIP);
      // ahb data phase: write the control register
      if (st_reg.dph_wr && (st_reg.dph_addr == tsk_pkg::ADDR_IRQ_CTRL2)) begin
         st_next.ctrl2 = i_hwdata[tsk_pkg::CTRL_W-1:0]; // [RULE_04]
      end
      // ahb address phase: capture and prepare read data
      st_next.dph_wr = ahb_take && i_hwrite;
      st_next.dph_addr = i_haddr[tsk_pkg::ADDR_W-1:0];
      if (ahb_take && !i_hwrite) begin
         unique case (i_haddr[tsk_pkg::ADDR_W-1:0])
            tsk_pkg::ADDR_IRQ_CTRL2: begin
               st_next.hrdata = {28'h0000000, st_reg.ctrl2};
            end
            tsk_pkg::ADDR_STATUS: begin
               st_next.hrdata = status_word(st_reg);
            end
            default: begin
               st_next.hrdata = tsk_pkg::WORD_ZERO; // unmapped reads zero
            end
         endcase
      end
      st_next.hreadyout = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         st_reg.seq <= tsk_pkg::SEQ_EXEC;
         st_reg.skip_pending <= 1'b0;
         st_reg.suppressed <= 1'b0;
         st_reg.t3_flag <= 1'b0;
         st_reg.ref_flag <= 1'b0;
         st_reg.vdet_en <= 1'b0;
         st_reg.sreset <= 1'b0;
         st_reg.ctrl2 <= tsk_pkg::CTRL_RST;
         st_reg.dph_wr <= 1'b0;
         st_reg.dph_addr <= 8'h00;
         st_reg.hrdata <= tsk_pkg::WORD_ZERO;
         st_reg.hreadyout <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs straight from the state register, except o_hresp, which is tied to zero
   assign o_hrdata = st_reg.hrdata;
   assign o_hreadyout = st_reg.hreadyout;
   assign o_hresp = 1'b0;
   assign o_skip_pending = st_reg.skip_pending;
   assign o_suppressed = st_reg.suppressed;
   assign o_t3_flag = st_reg.t3_flag;
   assign o_ref_flag = st_reg.ref_flag;
   assign o_vdet_powerdown_en = st_reg.vdet_en;
   assign o_sys_reset_req = st_reg.sreset;
   assign o_irq_ctrl2 = st_reg.ctrl2;

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_nrst);

   a_skip_on_flag: assert property ( // [RULE_01]
      (exec && is_op(i_instr, tsk_pkg::OP_SKIP_T3) && !t3_en)
      |=> (o_skip_pending == $past(o_t3_flag)))
      else $error("skip op did not follow request flag");

   a_flag_cleared: assert property ( // [RULE_02]
      (exec && is_op(i_instr, tsk_pkg::OP_SKIP_T3) && !t3_en && !i_t3_event)
      |=> !o_t3_flag)
      else $error("skip op left request flag set");

   a_nop_when_en: assert property ( // [RULE_03]
      (exec && is_op(i_instr, tsk_pkg::OP_SKIP_T3) && t3_en)
      |=> (!o_skip_pending && (o_t3_flag == ($past(o_t3_flag) || $past(i_t3_event)))))
      else $error("skip op acted while enable set");

   a_ctrl_bit0: assert property ( // [RULE_04]
      (st_reg.dph_wr && (st_reg.dph_addr == tsk_pkg::ADDR_IRQ_CTRL2))
      |=> (o_irq_ctrl2[tsk_pkg::IRQ2_T3_EN_BIT] == $past(i_hwdata[tsk_pkg::IRQ2_T3_EN_BIT])))
      else $error("enable bit not written from data bit 0");

   a_ref_set: assert property ( // [RULE_05]
      (exec && is_op(i_instr, tsk_pkg::OP_SET_REF))
      |=> (o_ref_flag && !o_skip_pending) ##1 o_ref_flag)
      else $error("reference flag not set or skip raised");

   a_vdet_held: assert property ( // [RULE_06]
      (exec && is_op(i_instr, tsk_pkg::OP_VDET_EN)) |=> o_vdet_powerdown_en [*3])
      else $error("detector enable not held");

   a_skip_one: assert property ( // [RULE_07]
      (o_skip_pending && i_instr.valid)
      |=> (o_suppressed && !o_skip_pending && $stable(o_ref_flag)
           && $stable(o_vdet_powerdown_en) && !o_sys_reset_req))
      else $error("skipped instruction had effects");

   // timer event and skip-op clear in one cycle: the set must win
   a_flag_set_wins: assert property (
      i_t3_event |=> o_t3_flag)
      else $error("timer event lost against a clear");

   // a dropped slot is reported by a single one-cycle pulse
   a_suppress_once: assert property (
      o_suppressed |=> !o_suppressed)
      else $error("suppressed pulse longer than one cycle");

   // software reset op raises its request pulse on the next cycle
   a_sreset_op: assert property (
      (exec && is_op(i_instr, tsk_pkg::OP_SW_RESET)) |=> o_sys_reset_req)
      else $error("software reset op gave no reset request");

   // read of the control register returns its value at the address phase
   a_read_ctrl: assert property (
      (ahb_take && !i_hwrite && (i_haddr[tsk_pkg::ADDR_W-1:0] == tsk_pkg::ADDR_IRQ_CTRL2))
      |=> (o_hrdata[tsk_pkg::CTRL_W-1:0] == $past(o_irq_ctrl2)))
      else $error("control register read data wrong");

   c_skip_taken: cover property (o_skip_pending ##[1:4] o_suppressed);
   c_nop_case: cover property (exec && is_op(i_instr, tsk_pkg::OP_SKIP_T3) && t3_en);
   c_ctrl_write: cover property (st_reg.dph_wr ##1 o_irq_ctrl2[tsk_pkg::IRQ2_T3_EN_BIT]);
endmodule : tsk_decoder

// >>> test/timer3_skip_and_misc_ops_tb.sv
// self-checking bench for the timer 3 skip and miscellaneous op decoder
`timescale 1ns/10ps
module timer3_skip_and_misc_ops_tb;
   // one table row: enable bit, timer event, op, status {skip,vdet,ref,t3}
   typedef struct packed {
      logic en;
      logic ev;
      logic [9:0] code;
      logic [3:0] stat;
   } tsk_row_t;
   // stimulus
   logic clk = 1'h0;
   logic nrst = 1'h0;
   tsk_pkg::tsk_instr_t instr = '0;
   logic t3_ev = 1'h0;
   logic hsel = 1'h0;
   logic hwrite = 1'h0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   // observed outputs
   logic [31:0] hrdata;
   logic hready, hresp, skip_p, supp, t3_req, reff, vdet, sys_rst;
   logic [11:0] outs; // all single-bit outputs and the control port, msb first
   logic [3:0] ctrl2;
   logic [31:0] rd;
   int err_count = 0;
   int tests_run = 0;
   int cyc = 0;
   tsk_row_t rows [4] = '{
      '{1'h0, 1'h1, tsk_pkg::OP_SKIP_T3, 4'h8},
      '{1'h0, 1'h0, tsk_pkg::OP_SKIP_T3, 4'h0},
      '{1'h1, 1'h1, tsk_pkg::OP_SKIP_T3, 4'h1},
      '{1'h0, 1'h1, tsk_pkg::OP_SET_REF, 4'h3}};

   always #2.5 clk = ~clk; // 200 MHz

   tsk_decoder dut (.i_clock(clk), .i_nrst(nrst), .i_instr(instr), .i_t3_event(t3_ev),
      .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
      .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
      .o_hreadyout(hready), .o_hresp(hresp), .o_skip_pending(skip_p),
      .o_suppressed(supp), .o_t3_flag(t3_req), .o_ref_flag(reff),
      .o_vdet_powerdown_en(vdet), .o_sys_reset_req(sys_rst), .o_irq_ctrl2(ctrl2));
   assign outs = {hready, hresp, skip_p, supp, t3_req, reff, vdet, sys_rst, ctrl2};

   ////////////////////////////////////////////////////////////////////////
   // compare, report and finish
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : wrap_up

   // hang guard: whole run needs well under this many cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         err_count++;
         wrap_up();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // reset pulse of n cycles
   task automatic rst(input int n);
      nrst <= 1'h0;
      repeat (n) @(posedge clk);
      nrst <= 1'h1;
   endtask : rst

   // single ahb-lite word transfer, read data lands in rd
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'h1;
      htrans <= tsk_pkg::HTRANS_NONSEQ;
      hwrite <= wr;
      haddr <= {24'h0, a};
      @(posedge clk);
      while (hready !== 1'h1) @(posedge clk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (hready !== 1'h1) @(posedge clk);
      rd = hrdata;
   endtask : bus

   // one instruction slot, then settle past the taking edge
   task automatic op(input logic [9:0] c);
      @(posedge clk);
      instr <= {1'h1, c};
      @(posedge clk);
      instr <= '0;
      #1;
   endtask : op

   // one-cycle timer request event
   task automatic pulse;
      @(posedge clk);
      t3_ev <= 1'h1;
      @(posedge clk);
      t3_ev <= 1'h0;
   endtask : pulse

   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      rst(20);
      #1 chk("reset outputs", 32'h800, outs);
      $display("reset done");
      // table cases: each row from a fresh reset
      foreach (rows[i]) begin
         rst(2);
         bus(1'h1, tsk_pkg::ADDR_IRQ_CTRL2, {31'h0, rows[i].en});
         bus(1'h0, tsk_pkg::ADDR_IRQ_CTRL2, 32'h0);
         chk("ctrl2", {31'h0, rows[i].en}, rd);
         chk("ctrl2 port", {31'h0, rows[i].en}, ctrl2);
         if (rows[i].ev) pulse();
         op(rows[i].code);
         bus(1'h0, tsk_pkg::ADDR_STATUS, 32'h0);
         chk("status", {28'h0, rows[i].stat}, rd);
         op(tsk_pkg::OP_VDET_EN);
         chk("suppressed", rows[i].stat[3], supp);
         chk("detector", !rows[i].stat[3], vdet);
         $display("row %0d done", i);
      end
      // skip followed back to back by a dropped slot
      rst(2);
      pulse();
      @(posedge clk);
      instr <= {1'h1, tsk_pkg::OP_SKIP_T3};
      @(posedge clk);
      instr <= {1'h1, tsk_pkg::OP_SET_REF};
      @(posedge clk);
      instr <= '0;
      #1 chk("b2b suppressed", 32'h1, supp);
      chk("b2b ref", 32'h0, reff);
      op(tsk_pkg::OP_SET_REF);
      chk("ref set", {31'h0, 1'h1}, {skip_p, reff});
      $display("back to back done");
      // unmapped read and software reset pulse
      bus(1'h0, 8'h08, 32'h0);
      chk("unmapped", 32'h0, rd);
      chk("hresp", 32'h0, hresp);
      op(tsk_pkg::OP_SW_RESET);
      chk("sreset pulse", 32'h1, sys_rst);
      @(posedge clk);
      #1 chk("sreset end", 32'h0, sys_rst);
      $display("misc done");
      // mid-run reset clears the sticky flags, which stay clear one edge on
      op(tsk_pkg::OP_VDET_EN);
      rst(2);
      #1 chk("reset again", 32'h800, outs);
      @(posedge clk);
      #1 chk("reset held", 32'h800, outs);
      $display("mid reset done");
      wrap_up();
   end
endmodule : timer3_skip_and_misc_ops_tb
